// *** dv/rsi_host_model.sv ***
`timescale 1ns/1ps
module rsi_host_model (
  input  wire logic       core_clk,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata
);
  initial begin
    {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
  end
  // never programs trigger code 11
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk) {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
    @(posedge core_clk) {reg_addr, reg_wdata, reg_wr} <= {~a, ~d, 1'b0};
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk) {reg_addr, reg_rd} <= {a, 1'b1};
    @(posedge core_clk) {reg_addr, reg_rd} <= {~a, 1'b0};
    #1 d = reg_rdata;
  endtask : rd
endmodule : rsi_host_model

// *** dv/rsi_receiver_status_irq_bench.sv ***
`timescale 1ns/1ps
module rsi_receiver_status_irq_bench;
  import rsi_pkg::*;
  logic       core_clk, rst_n, reg_wr, reg_rd, rx_irq, gpo_rx_irq_n;
  logic       a_rx, a_sl, fsa, fsr, b_rx, b_sl, fsb;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rv, src;
  logic [5:0] cnt;
  logic [3:0] gsel;
  int         n_fail, cmp_count;
  rsi_host_model rsi_host_model_inst (.core_clk, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata);
  rsi_receiver_status_irq rsi_receiver_status_irq_inst (.core_clk, .rst_n,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .status_crc_err(src[7]), .parity_err(src[6]), .validity_flag(src[5]),
    .biphase_err(src[4]), .subcode_change(src[3]),
    .decoder_locked(~src[2]), .receiver_recovery_pll_locked(~src[2]),
    .subcode_crc_err(src[1]), .buffer_xfer_pulse(src[0]),
    .port_a_from_rx(a_rx), .port_a_slave(a_sl), .port_b_from_rx(b_rx),
    .port_b_slave(b_sl), .frame_sync_clock_a(fsa),
    .frame_sync_clock_b(fsb), .rx_frame_sync(fsr), .gpo_select(gsel),
    .rx_irq, .gpo_rx_irq_n);
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  // port frame sync lags the receiver one cycle of 64
  // port b frame sync sits half a frame off, outside the window
  always @(posedge core_clk) begin
    if (!rst_n) begin
      {cnt, fsr, fsa, fsb} <= '0;
    end else begin
      cnt <= cnt + 6'h01;
      fsr <= cnt[5];
      fsa <= fsr;
      fsb <= ~fsr;
    end
  end
  task automatic cmp8(string n, logic [7:0] e, logic [7:0] s);
    cmp_count++;
    if (s !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : cmp8
  task automatic chk_reg(logic [7:0] a, logic [7:0] e);
    rsi_host_model_inst.rd(a, rv);
    cmp8("reg_rdata", e, rv);
  endtask : chk_reg
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : stop_test
  initial begin
    #50000;
    n_fail++;
    stop_test();
  end
  initial begin
    {rst_n, src, a_rx, a_sl, b_rx, b_sl, gsel} = '0;
    n_fail = 0;
    cmp_count = 0;
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    for (int a = 8'h15; a <= 8'h1A; a++) begin
      chk_reg(a[7:0], 8'h00);
    end
    cmp8("irq_pins", 8'h01, {6'h00, rx_irq, gpo_rx_irq_n});
    rsi_host_model_inst.wr(8'h16, 8'hA5);
    chk_reg(8'h16, 8'hA5);
    rsi_host_model_inst.wr(8'h17, 8'hFF);
    chk_reg(8'h17, 8'h01);
    rsi_host_model_inst.wr(8'h15, 8'hFF);
    chk_reg(8'h15, 8'h00);
    rsi_host_model_inst.wr(8'h18, 8'h86);
    chk_reg(8'h18, 8'h86);
    rsi_host_model_inst.wr(8'h19, 8'h96);
    chk_reg(8'h19, 8'h96);
    rsi_host_model_inst.wr(8'h1A, 8'hFE);
    chk_reg(8'h1A, 8'h02);
    chk_reg(8'h3C, 8'h00);
    rsi_host_model_inst.wr(8'h18, 8'h00);
    rsi_host_model_inst.wr(8'h16, 8'h00);
    rsi_host_model_inst.wr(8'h17, 8'h00);
    rsi_host_model_inst.wr(8'h19, 8'h00);
    rsi_host_model_inst.wr(8'h1A, 8'h00);
    @(posedge core_clk) src <= 8'h01;
    @(posedge core_clk) src <= 8'h00;
    chk_reg(8'h14, 8'h01);
    cmp8("rx_irq", 8'h00, {7'h00, rx_irq});
    @(posedge core_clk) gsel <= RSI_GPO_SEL_RX_IRQ;
    for (int i = 0; i < 8; i++) begin
      rsi_host_model_inst.wr(8'h16, 8'h01 << i);
      @(posedge core_clk) src <= 8'h01 << i;
      @(posedge core_clk) src <= 8'h00;
      repeat (4) @(posedge core_clk);
      #1 cmp8("irq_pins", 8'h02, {6'h00, rx_irq, gpo_rx_irq_n});
      rsi_host_model_inst.rd(8'h14, rv);
      cmp8("buffer_done", {7'h00, i == 0}, {7'h00, rv[0]});
      repeat (2) @(posedge core_clk);
      #1 cmp8("irq_pins", 8'h01, {6'h00, rx_irq, gpo_rx_irq_n});
    end
    rsi_host_model_inst.wr(8'h16, 8'h08);
    for (int m = 0; m < 3; m++) begin
      rsi_host_model_inst.wr(8'h18, 8'(m << 6));
      rsi_host_model_inst.rd(8'h14, rv);
      @(posedge core_clk) src <= 8'h08;
      repeat (5) @(posedge core_clk);
      #1 cmp8("rx_irq", {7'h00, m != 1}, {7'h00, rx_irq});
      @(posedge core_clk) src <= 8'h00;
      repeat (5) @(posedge core_clk);
      #1 cmp8("rx_irq", 8'h01, {7'h00, rx_irq});
      rsi_host_model_inst.rd(8'h14, rv);
      repeat (2) @(posedge core_clk);
      #1 cmp8("rx_irq", 8'h00, {7'h00, rx_irq});
    end
    rsi_host_model_inst.wr(8'h17, 8'h01);
    @(posedge core_clk) {a_rx, b_rx, b_sl} <= 3'b111;
    repeat (300) @(posedge core_clk);
    chk_reg(8'h15, 8'h00);
    @(posedge core_clk) a_sl <= 1'b1;
    repeat (300) @(posedge core_clk);
    #1 cmp8("rx_irq", 8'h01, {7'h00, rx_irq});
    @(posedge core_clk) gsel <= 4'h0;
    repeat (2) @(posedge core_clk);
    #1 cmp8("irq_pins", 8'h03, {6'h00, rx_irq, gpo_rx_irq_n});
    chk_reg(8'h15, 8'h01);
    @(posedge core_clk) a_rx <= 1'b0;
    repeat (300) @(posedge core_clk);
    rsi_host_model_inst.rd(8'h15, rv);
    repeat (300) @(posedge core_clk);
    chk_reg(8'h15, 8'h00);
    stop_test();
  end
endmodule : rsi_receiver_status_irq_bench

// *** dv/rsi_receiver_status_irq_monitor.sv ***
`timescale 1ns/1ps
module rsi_receiver_status_irq_monitor
  import rsi_pkg::*;
(
  input wire logic       core_clk,
  input wire logic       rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       buffer_xfer_pulse,
  input wire logic [3:0] gpo_select,
  input wire logic       rx_irq,
  input wire logic       gpo_rx_irq_n
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence s_wr_rd(logic [7:0] a);
    reg_wr && reg_addr == a ##2 reg_rd && reg_addr == a;
  endsequence
  sequence s_xfer_rd;
    buffer_xfer_pulse ##2 reg_rd && reg_addr == RSI_ADDR_STATUS_TWO;
  endsequence
  property p_xfer;
    s_xfer_rd |=> reg_rdata[RSI_BIT_BUFFER_XFER];
  endproperty
  a_xfer: assert property (p_xfer)
    else $error("buffer transfer status missing");
  property p_st3;
    reg_rd && reg_addr == RSI_ADDR_STATUS_THREE |=> reg_rdata[7:1] == 7'h00;
  endproperty
  a_st3: assert property (p_st3)
    else $error("status three upper bits set");
  property p_en1_rw;
    s_wr_rd(RSI_ADDR_ENABLE_ONE) |=> reg_rdata == $past(reg_wdata, 3);
  endproperty
  a_en1_rw: assert property (p_en1_rw)
    else $error("enable one readback wrong");
  property p_en2_rw;
    s_wr_rd(RSI_ADDR_ENABLE_TWO) |=>
      reg_rdata == {7'h00, $past(reg_wdata[0], 3)};
  endproperty
  a_en2_rw: assert property (p_en2_rw)
    else $error("enable two readback wrong");
  property p_trig_rw;
    s_wr_rd(RSI_ADDR_TRIGGER_ONE) |=> reg_rdata == $past(reg_wdata, 3);
  endproperty
  a_trig_rw: assert property (p_trig_rw)
    else $error("trigger one readback wrong");
  property p_unmapped;
    reg_rd && reg_addr > RSI_ADDR_TRIGGER_THREE |=> reg_rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  property p_irq_hold;
    rx_irq && !(reg_rd && reg_addr inside {8'h14, 8'h15}) |=> rx_irq;
  endproperty
  a_irq_hold: assert property (p_irq_hold)
    else $error("request dropped without status read");
  property p_gpo;
    gpo_rx_irq_n ==
      !($past(rx_irq) && $past(gpo_select) == RSI_GPO_SEL_RX_IRQ);
  endproperty
  a_gpo: assert property (p_gpo)
    else $error("general output level wrong");
endmodule : rsi_receiver_status_irq_monitor
bind rsi_receiver_status_irq rsi_receiver_status_irq_monitor
  rsi_receiver_status_irq_monitor_inst (.core_clk, .rst_n, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .buffer_xfer_pulse,
  .gpo_select, .rx_irq, .gpo_rx_irq_n);

// *** src/rsi_pkg.sv ***
package rsi_pkg;
  // register addresses
  localparam logic [7:0] RSI_ADDR_STATUS_TWO  = 8'h14;
  localparam logic [7:0] RSI_ADDR_STATUS_THREE = 8'h15;
  localparam logic [7:0] RSI_ADDR_ENABLE_ONE  = 8'h16;
  localparam logic [7:0] RSI_ADDR_ENABLE_TWO  = 8'h17;
  localparam logic [7:0] RSI_ADDR_TRIGGER_ONE = 8'h18;
  localparam logic [7:0] RSI_ADDR_TRIGGER_TWO = 8'h19;
  localparam logic [7:0] RSI_ADDR_TRIGGER_THREE = 8'h1A;
  // reset values
  localparam logic [7:0] RSI_ENABLE_RESET  = 8'h00;
  localparam logic [7:0] RSI_TRIGGER_RESET = 8'h00;
  // source bit positions in status two / enable one, slip bit in enable two
  localparam int RSI_BIT_STATUS_CRC     = 7;
  localparam int RSI_BIT_PARITY         = 6;
  localparam int RSI_BIT_VALIDITY       = 5;
  localparam int RSI_BIT_BIPHASE        = 4;
  localparam int RSI_BIT_SUBCODE_CHANGE = 3;
  localparam int RSI_BIT_LOCK_LOSS      = 2;
  localparam int RSI_BIT_SUBCODE_CRC    = 1;
  localparam int RSI_BIT_BUFFER_XFER    = 0;
  localparam int RSI_BIT_OUTPUT_SLIP    = 0;
  localparam int RSI_NUM_SOURCES        = 9;
  localparam int RSI_SLIP_SOURCE        = 8;
  // slip window: +/-5 percent of the frame period
  localparam int RSI_SLIP_WINDOW_PCT    = 5;
  localparam int RSI_PERIOD_W           = 16;
  // general-purpose output selector for receiver interrupt
  localparam logic [3:0] RSI_GPO_SEL_RX_IRQ = 4'h4;

  typedef enum logic [1:0] {
    RSI_TRIG_RISE  = 2'b00,
    RSI_TRIG_FALL  = 2'b01,
    RSI_TRIG_LEVEL = 2'b10,
    RSI_TRIG_RSVD  = 2'b11
  } rsi_trig_t;
endpackage : rsi_pkg

// *** src/rsi_receiver_status_irq.sv ***
`timescale 1ns/1ps
// Behaviour
// R1 - buffer-transfer status reads 1 after a completed transfer, else 0.
// R2 - status three is read-only with the slip flag in bit 0, others zero.
// R3 - slip interrupts only when the enable in the 0x17 mask is set.
// R4 - slip is raised only when a receiver-fed port runs in slave mode.
// R5 - with one receiver-fed port slip tracks it; with both, port A only.
// R6 - slip is flagged when frame sync edges fall in the +/-5 percent window.
// R7 - mask one holds eight source enables, 0 masks (reset) and 1 enables.
// R8 - mask two holds the slip enable in bit 0, reset 0, upper bits zero.
// R9 - trigger mode one holds four 2-bit fields for the listed sources.
// R10 - trigger codes: 00 rising (reset), 01 falling, 10 level, 11 reserved.
// R11 - status two bits interrupt only when enabled in the 0x16 mask.
// R12 - unlock reads 0 when decoder and recovery pll lock, else 1.
// R13 - the receiver interrupt is offered active low on a general output.
// R14 - enabled, mode-qualified sources merge into one held request.
// R15 - a masked source still updates status but raises no request.
module rsi_receiver_status_irq
  import rsi_pkg::*;
(
  input  wire logic                    core_clk,
  input  wire logic                    rst_n,
  input  wire logic [7:0]              reg_addr,
  input  wire logic [7:0]              reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output logic      [7:0]              reg_rdata,
  input  wire logic                    status_crc_err,
  input  wire logic                    parity_err,
  input  wire logic                    validity_flag,
  input  wire logic                    biphase_err,
  input  wire logic                    subcode_change,
  input  wire logic                    decoder_locked,
  input  wire logic                    receiver_recovery_pll_locked,
  input  wire logic                    subcode_crc_err,
  input  wire logic                    buffer_xfer_pulse,
  input  wire logic                    port_a_from_rx,
  input  wire logic                    port_a_slave,
  input  wire logic                    port_b_from_rx,
  input  wire logic                    port_b_slave,
  input  wire logic                    frame_sync_clock_a,
  input  wire logic                    frame_sync_clock_b,
  input  wire logic                    rx_frame_sync,
  input  wire logic [3:0]              gpo_select,
  output logic                         rx_irq,
  output logic                         gpo_rx_irq_n
);
  logic [7:0] enable_one_q;
  logic [7:0] enable_two_q;
  logic [7:0] trigger_one_q;
  logic [7:0] trigger_two_q;
  logic [7:0] trigger_three_q;
  logic       buffer_transfer_done_q;
  logic       output_slip_error_q;
  logic       rx_irq_q;
  logic       gpo_rx_irq_n_q;
  logic [7:0] reg_rdata_q;
  logic [7:0] status_two;
  logic [RSI_NUM_SOURCES-1:0] src_level;
  logic [RSI_NUM_SOURCES-1:0] src_enable;
  logic [2*RSI_NUM_SOURCES-1:0] src_mode;
  logic [RSI_NUM_SOURCES-1:0] src_hit;
  logic       wr_en1;
  logic       rd_st2;
  logic       wr_en2;
  logic       wr_tr1;
  logic       wr_tr2;
  logic       wr_tr3;
  logic       rd_st3;
  // named enables and trigger fields
  logic       status_crc_irq_enable;
  logic       parity_irq_enable;
  logic       validity_irq_enable;
  logic       biphase_irq_enable;
  logic       subcode_change_irq_enable;
  logic       lock_loss_irq_enable;
  logic       subcode_crc_irq_enable;
  logic       buffer_transfer_irq_enable;
  logic       output_slip_irq_enable;
  logic [1:0] subcode_change_trigger;
  logic [1:0] lock_loss_trigger;
  logic [1:0] subcode_crc_trigger;
  logic [1:0] buffer_transfer_trigger;

  // per-register strobes
  assign wr_en1 = reg_wr & (reg_addr == RSI_ADDR_ENABLE_ONE);
  assign wr_en2 = reg_wr & (reg_addr == RSI_ADDR_ENABLE_TWO);
  assign wr_tr1 = reg_wr & (reg_addr == RSI_ADDR_TRIGGER_ONE);
  assign wr_tr2 = reg_wr & (reg_addr == RSI_ADDR_TRIGGER_TWO);
  assign wr_tr3 = reg_wr & (reg_addr == RSI_ADDR_TRIGGER_THREE);
  assign rd_st2 = reg_rd & (reg_addr == RSI_ADDR_STATUS_TWO);
  assign rd_st3 = reg_rd & (reg_addr == RSI_ADDR_STATUS_THREE);

  // mask one
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      enable_one_q <= RSI_ENABLE_RESET; // [R7]
    end else if (wr_en1) begin
      enable_one_q <= reg_wdata; // [R7]
    end
  end

  // mask two, slip enable only
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      enable_two_q <= RSI_ENABLE_RESET; // [R8]
    end else if (wr_en2) begin
      enable_two_q <= {7'h00, reg_wdata[RSI_BIT_OUTPUT_SLIP]}; // [R8]
    end
  end

  // trigger mode one
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      trigger_one_q <= RSI_TRIGGER_RESET; // [R10]
    end else if (wr_tr1) begin
      trigger_one_q <= reg_wdata; // [R9]
    end
  end

  // trigger mode two
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      trigger_two_q <= RSI_TRIGGER_RESET; // [R10]
    end else if (wr_tr2) begin
      trigger_two_q <= reg_wdata;
    end
  end

  // trigger mode three, slip field only
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      trigger_three_q <= RSI_TRIGGER_RESET; // [R10]
    end else if (wr_tr3) begin
      trigger_three_q <= {6'h00, reg_wdata[1:0]};
    end
  end

  // field views by source
  assign status_crc_irq_enable      = enable_one_q[RSI_BIT_STATUS_CRC];
  assign parity_irq_enable          = enable_one_q[RSI_BIT_PARITY];
  assign validity_irq_enable        = enable_one_q[RSI_BIT_VALIDITY];
  assign biphase_irq_enable         = enable_one_q[RSI_BIT_BIPHASE];
  assign subcode_change_irq_enable  = enable_one_q[RSI_BIT_SUBCODE_CHANGE];
  assign lock_loss_irq_enable       = enable_one_q[RSI_BIT_LOCK_LOSS];
  assign subcode_crc_irq_enable     = enable_one_q[RSI_BIT_SUBCODE_CRC];
  assign buffer_transfer_irq_enable = enable_one_q[RSI_BIT_BUFFER_XFER];
  assign output_slip_irq_enable     = enable_two_q[RSI_BIT_OUTPUT_SLIP];
  assign subcode_change_trigger  = trigger_one_q[2*RSI_BIT_SUBCODE_CHANGE+:2];
  assign lock_loss_trigger       = trigger_one_q[2*RSI_BIT_LOCK_LOSS+:2];
  assign subcode_crc_trigger     = trigger_one_q[2*RSI_BIT_SUBCODE_CRC+:2];
  assign buffer_transfer_trigger = trigger_one_q[2*RSI_BIT_BUFFER_XFER+:2];

  // buffer transfer done: set by pulse, cleared on read of status two
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      buffer_transfer_done_q <= 1'b0;
    end else if (buffer_xfer_pulse) begin
      buffer_transfer_done_q <= 1'b1; // [R1]
    end else if (rd_st2) begin
      buffer_transfer_done_q <= 1'b0; // [R1]
    end
  end

  // slip detection on the tracked slave port
  logic       slip_armed;
  logic       track_fs;
  logic       fs_prev_q;
  logic       rx_prev_q;
  logic [RSI_PERIOD_W-1:0] period_cnt_q;
  logic [RSI_PERIOD_W-1:0] period_q;
  logic [RSI_PERIOD_W-1:0] since_rx_q;
  logic [RSI_PERIOD_W-1:0] slip_win;
  logic       fs_edge;
  logic       rx_edge;
  logic       slip_hit;

  assign slip_armed = (port_a_from_rx & port_a_slave)
                    | (~port_a_from_rx & port_b_from_rx & port_b_slave); // [R4]
  assign track_fs   = port_a_from_rx ? frame_sync_clock_a
                                     : frame_sync_clock_b; // [R5]
  assign fs_edge  = track_fs & ~fs_prev_q;
  assign rx_edge  = rx_frame_sync & ~rx_prev_q;
  assign slip_win = RSI_PERIOD_W'((32'(period_q) * RSI_SLIP_WINDOW_PCT)
                                  / 100);
  // port edge lands within the window around the receiver edge
  assign slip_hit = slip_armed & fs_edge & (period_q != '0)
                  & ((since_rx_q <= slip_win)
                     | (since_rx_q >= period_q - slip_win)); // [R6]

  // edge history of both frame syncs
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      fs_prev_q <= 1'b0;
      rx_prev_q <= 1'b0;
    end else begin
      fs_prev_q <= track_fs;
      rx_prev_q <= rx_frame_sync;
    end
  end

  // tracked port frame period
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      period_cnt_q <= '0;
      period_q     <= '0;
    end else if (fs_edge) begin
      period_q     <= period_cnt_q;
      period_cnt_q <= '0;
    end else if (period_cnt_q != '1) begin
      period_cnt_q <= period_cnt_q + 1'b1;
    end
  end

  // cycles since the receiver frame edge
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      since_rx_q <= '0;
    end else if (rx_edge) begin
      since_rx_q <= '0;
    end else if (since_rx_q != '1) begin
      since_rx_q <= since_rx_q + 1'b1;
    end
  end

  // slip flag: set wins over clear-on-read of status three
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      output_slip_error_q <= 1'b0;
    end else if (slip_hit) begin
      output_slip_error_q <= 1'b1; // [R2]
    end else if (rd_st3) begin
      output_slip_error_q <= 1'b0;
    end
  end

  assign status_two = {status_crc_err, parity_err, validity_flag, biphase_err,
                       subcode_change,
                       ~(decoder_locked & receiver_recovery_pll_locked), // [R12]
                       subcode_crc_err, buffer_transfer_done_q};

  assign src_level  = {output_slip_error_q, status_two};
  assign src_enable = {output_slip_irq_enable, status_crc_irq_enable,
                       parity_irq_enable, validity_irq_enable,
                       biphase_irq_enable, subcode_change_irq_enable,
                       lock_loss_irq_enable, subcode_crc_irq_enable,
                       buffer_transfer_irq_enable}; // [R3]
  assign src_mode   = {trigger_three_q[1:0], trigger_two_q,
                       subcode_change_trigger, lock_loss_trigger,
                       subcode_crc_trigger, buffer_transfer_trigger};

  genvar gi;
  generate
    for (gi = 0; gi < RSI_NUM_SOURCES; gi++) begin : g_src
      rsi_trigger u_trig (
        .core_clk  (core_clk),
        .rst_n     (rst_n),
        .src_level (src_level[gi]),
        .trig_mode (src_mode[2*gi +: 2]),
        .enable    (src_enable[gi]), // [R11]
        .event_hit (src_hit[gi])
      );
    end
  endgenerate

  // request held until host reads status two or three
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rx_irq_q <= 1'b0;
    end else if (|src_hit) begin
      rx_irq_q <= 1'b1; // [R14]
    end else if (rd_st2 || rd_st3) begin
      rx_irq_q <= 1'b0; // [R14]
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      gpo_rx_irq_n_q <= 1'b1;
    end else begin
      gpo_rx_irq_n_q <= ~((gpo_select == RSI_GPO_SEL_RX_IRQ) & rx_irq_q); // [R13]
    end
  end

  // read data, registered
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      reg_rdata_q <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        RSI_ADDR_STATUS_TWO:    reg_rdata_q <= status_two;
        RSI_ADDR_STATUS_THREE:  reg_rdata_q <= {7'h00, output_slip_error_q}; // [R2]
        RSI_ADDR_ENABLE_ONE:    reg_rdata_q <= enable_one_q;
        RSI_ADDR_ENABLE_TWO:    reg_rdata_q <= enable_two_q;
        RSI_ADDR_TRIGGER_ONE:   reg_rdata_q <= trigger_one_q;
        RSI_ADDR_TRIGGER_TWO:   reg_rdata_q <= trigger_two_q;
        RSI_ADDR_TRIGGER_THREE: reg_rdata_q <= trigger_three_q;
        default:                reg_rdata_q <= 8'h00;
      endcase
    end
  end

  assign reg_rdata    = reg_rdata_q;
  assign rx_irq       = rx_irq_q;
  assign gpo_rx_irq_n = gpo_rx_irq_n_q;
endmodule : rsi_receiver_status_irq

// *** src/rsi_trigger.sv ***
`timescale 1ns/1ps
module rsi_trigger
  import rsi_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic       src_level,
  input  wire logic [1:0] trig_mode,
  input  wire logic       enable,
  output logic            event_hit
);
  logic prev_q;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= src_level;
    end
  end

  // mode-qualified trigger, gated by enable
  always_comb begin
    case (rsi_trig_t'(trig_mode))
      RSI_TRIG_RISE:  event_hit = src_level & ~prev_q; // [R10]
      RSI_TRIG_FALL:  event_hit = ~src_level & prev_q; // [R10]
      RSI_TRIG_LEVEL: event_hit = src_level; // [R10]
      default:        event_hit = 1'b0;
    endcase
    event_hit = event_hit & enable; // [R15]
  end
endmodule : rsi_trigger
